// >>> dac_serial_load_pkg.sv
package dac_serial_load_pkg;

	localparam int          FRAME_BITS     = 24;
	localparam int          CNT_W          = 5;
	localparam logic [23:0] ZERO_SCALE     = 24'h000000;
	localparam logic [4:0]  CNT_RESET      = 5'h00;
	localparam logic [4:0]  CNT_FULL       = 5'h18;
	localparam logic [7:0]  CTRL_DEFAULT   = 8'h00;
	localparam logic [1:0]  SYNC_RESET     = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_DONE  = 3'b100
	} frame_state_t;

endpackage

// >>> dac_serial_load_control.sv
// Summary of operation
// RULE_01: Load strobe low pulse copies new input data.
// RULE_02: Strobe held low updates converter after writes.
// RULE_03: Reset acts on low level, held.
// RULE_04: During reset ignore strobe and serial data.
// RULE_05: During reset both registers hold defaults.
// RULE_06: During reset ground the analog output.
// RULE_07: Capture serial bits on falling serial clock.
// RULE_08: Host frames each write with select low.
// RULE_09: Select low enables clock, data and shifter.
// RULE_10: Frame is 24 bits on following falls.
// RULE_11: Input shift register is 24 bits wide.
// RULE_12: Host keeps serial clock at most 50 MHz.
// RULE_13: Reset loads zero scale and control defaults.
// RULE_14: Short frames are discarded without any change.
`timescale 1ns/100ps
module dac_serial_load_control (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        sclk,
	input  wire logic        frame_sel_n,
	input  wire logic        serial_in,
	input  wire logic        load_strobe_n,
	input  wire logic        reset_n,
	output logic      [23:0] inputWord,
	output logic      [23:0] dacWord,
	output logic      [7:0]  ctrlWord,
	output logic             outGround,
	output logic             newData,
	output logic             frameActive
);

	// Two-stage synchronisers for all pins; bit 0 is the first stage only.
	logic [1:0] sclkSync_ff;
	logic [1:0] selSync_ff;
	logic [1:0] sdiSync_ff;
	logic [1:0] ldSync_ff;
	logic [1:0] rstSync_ff;
	logic [1:0] nxt_sclkSync;
	logic [1:0] nxt_selSync;
	logic [1:0] nxt_sdiSync;
	logic [1:0] nxt_ldSync;
	logic [1:0] nxt_rstSync;
	logic       sclkPrev_ff;
	logic       nxt_sclkPrev;
	logic       ldPrev_ff;
	logic       nxt_ldPrev;

	// A falling level between two samples of one synchronised pin.
	function automatic logic isFall(
		input logic prevLvl,
		input logic curLvl
	);
		return prevLvl & ~curLvl;
	endfunction

	// True in the state that follows the last captured bit of a frame.
	function automatic logic inDone(
		input dac_serial_load_pkg::frame_state_t st
	);
		return st == dac_serial_load_pkg::ST_DONE;
	endfunction

	always_comb
	begin
		nxt_sclkSync = {sclkSync_ff[0], sclk};
		nxt_selSync  = {selSync_ff[0],  frame_sel_n};
		nxt_sdiSync  = {sdiSync_ff[0],  serial_in};
		nxt_ldSync   = {ldSync_ff[0],   load_strobe_n};
		nxt_rstSync  = {rstSync_ff[0],  reset_n};
		nxt_sclkPrev = sclkSync_ff[1];
		nxt_ldPrev   = ldSync_ff[1];
		if (sys_rst)
		begin
			nxt_sclkSync = 2'h0;
			nxt_selSync  = dac_serial_load_pkg::SYNC_RESET;
			nxt_sdiSync  = 2'h0;
			nxt_ldSync   = dac_serial_load_pkg::SYNC_RESET;
			nxt_rstSync  = 2'h0;
			nxt_sclkPrev = 1'b0;
			nxt_ldPrev   = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		sclkSync_ff <= nxt_sclkSync;
		selSync_ff  <= nxt_selSync;
		sdiSync_ff  <= nxt_sdiSync;
		ldSync_ff   <= nxt_ldSync;
		rstSync_ff  <= nxt_rstSync;
		sclkPrev_ff <= nxt_sclkPrev;
		ldPrev_ff   <= nxt_ldPrev;
	end

	logic inReset;
	logic sclkFall;
	logic ldFall;
	logic selLow;
	logic ldLow;
	assign inReset  = ~rstSync_ff[1] | sys_rst;                     // see RULE_03
	assign selLow   = ~selSync_ff[1];
	assign sclkFall = isFall(sclkPrev_ff, sclkSync_ff[1]);
	assign ldLow    = ~ldSync_ff[1];
	assign ldFall   = isFall(ldPrev_ff, ldSync_ff[1]);

	dac_serial_load_pkg::frame_state_t state_ff, nxt_state;
	logic [23:0] shift_ff, nxt_shift;
	logic [4:0]  count_ff, nxt_count;
	logic [23:0] inReg_ff, nxt_inReg;
	logic [23:0] dacReg_ff, nxt_dacReg;
	logic [7:0]  ctrl_ff, nxt_ctrl;
	logic        pend_ff, nxt_pend;
	logic        gnd_ff, nxt_gnd;
	logic        frameAct_ff;
	logic        nxt_frameAct;
	logic        doneSeen_ff;
	logic        nxt_doneSeen;
	logic        landWord;

	// The first cycle in the done state is the one in which a finished word lands.
	assign landWord = inDone(state_ff) & ~doneSeen_ff;

	always_comb
	begin
		nxt_state  = state_ff;
		nxt_shift  = shift_ff;
		nxt_count  = count_ff;
		nxt_inReg  = inReg_ff;
		nxt_dacReg = dacReg_ff;
		nxt_ctrl   = ctrl_ff;
		nxt_pend   = pend_ff;
		nxt_gnd    = 1'b0;
		case (state_ff)
			dac_serial_load_pkg::ST_IDLE:
			begin
				if (selLow)
				begin
					nxt_state = dac_serial_load_pkg::ST_SHIFT;      // see RULE_09
					nxt_count = dac_serial_load_pkg::CNT_RESET;
				end
			end
			dac_serial_load_pkg::ST_SHIFT:
			begin
				if (!selLow)
				begin
					nxt_state = dac_serial_load_pkg::ST_IDLE;       // see RULE_14
				end
				else if (sclkFall)
				begin
					nxt_shift = {shift_ff[22:0], sdiSync_ff[1]};    // see RULE_07, RULE_11
					nxt_count = count_ff + 5'h01;
					if (count_ff == dac_serial_load_pkg::CNT_FULL - 5'h01)
					begin
						nxt_state = dac_serial_load_pkg::ST_DONE;   // see RULE_10
					end
				end
			end
			dac_serial_load_pkg::ST_DONE:
			begin
				// Extra edges after the 24th are not shifted in.
				nxt_inReg = shift_ff;                               // see RULE_14
				// The flag is raised once per frame, so a held select cannot re-arm a load.
				if (landWord)
				begin
					nxt_pend = 1'b1;                                // see RULE_02
				end
				if (!selLow)
				begin
					nxt_state = dac_serial_load_pkg::ST_IDLE;
				end
			end
			default:
			begin
				nxt_state = dac_serial_load_pkg::ST_IDLE;
			end
		endcase
		// A held-low strobe updates as soon as new data lands; a fall loads pending data.
		// Skipped while a word lands: the fresh word keeps its flag and loads next cycle.
		if (pend_ff && (ldFall || ldLow) && !landWord)
		begin
			nxt_dacReg = inReg_ff;                                  // see RULE_01, RULE_02
			nxt_pend   = 1'b0;
		end
		if (inReset)
		begin
			nxt_state  = dac_serial_load_pkg::ST_IDLE;              // see RULE_04
			nxt_shift  = dac_serial_load_pkg::ZERO_SCALE;
			nxt_count  = dac_serial_load_pkg::CNT_RESET;
			nxt_inReg  = dac_serial_load_pkg::ZERO_SCALE;           // see RULE_05, RULE_13
			nxt_dacReg = dac_serial_load_pkg::ZERO_SCALE;
			nxt_ctrl   = dac_serial_load_pkg::CTRL_DEFAULT;
			nxt_pend   = 1'b0;
			nxt_gnd    = 1'b1;                                      // see RULE_06
		end
	end

	always_ff @(posedge clk)
	begin
		state_ff  <= nxt_state;
		shift_ff  <= nxt_shift;
		count_ff  <= nxt_count;
		inReg_ff  <= nxt_inReg;
		dacReg_ff <= nxt_dacReg;
		ctrl_ff   <= nxt_ctrl;
		pend_ff   <= nxt_pend;
		gnd_ff    <= nxt_gnd;
	end

	// Remembers the done state one cycle on, so each finished frame lands only once.
	always_comb
	begin
		nxt_doneSeen = inDone(state_ff);
		nxt_frameAct = nxt_state == dac_serial_load_pkg::ST_SHIFT;
		if (sys_rst)
		begin
			nxt_doneSeen = 1'b0;
			nxt_frameAct = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		doneSeen_ff <= nxt_doneSeen;
		frameAct_ff <= nxt_frameAct;
	end

	assign inputWord   = inReg_ff;
	assign dacWord     = dacReg_ff;
	assign ctrlWord    = ctrl_ff;
	assign outGround   = gnd_ff;
	assign newData     = pend_ff;
	assign frameActive = frameAct_ff;

endmodule

// >>> dac_serial_load_control_monitor.sv
`timescale 1ns/100ps
module dac_serial_load_control_monitor (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        reset_n,
	input wire logic        load_strobe_n,
	input wire logic        frame_sel_n,
	input wire logic [23:0] inputWord,
	input wire logic [23:0] dacWord,
	input wire logic        outGround,
	input wire logic        newData,
	input wire logic        frameActive
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	ground_held_a: assert property (!reset_n[*6] |-> outGround)
		else $error("no ground");
	zero_held_a: assert property (!reset_n[*6] |-> !(|inputWord) && !(|dacWord))
		else $error("not zero");
	ground_clear_a: assert property (outGround |-> !newData && dacWord == 24'h0)
		else $error("busy in reset");
	auto_load_a: assert property ($rose(newData) && !load_strobe_n |-> ##[0:3] dacWord == inputWord)
		else $error("no auto load");
	no_load_a: assert property ((load_strobe_n && reset_n)[*4] |=> $stable(dacWord))
		else $error("stray load");
	load_copy_a: assert property ($fell(newData) |-> dacWord == inputWord)
		else $error("bad copy");
	idle_input_a: assert property ((frame_sel_n && reset_n)[*8] |=> $stable(inputWord))
		else $error("idle change");
	frame_start_a: assert property ($fell(frame_sel_n) && reset_n |-> ##[1:5] frameActive)
		else $error("no frame");
	cover property ($rose(newData));
	cover property ($fell(newData));
	cover property ($rose(outGround));
endmodule
bind dac_serial_load_control dac_serial_load_control_monitor dac_serial_load_control_monitor_inst (
	.clk           (clk),
	.sys_rst       (sys_rst),
	.reset_n       (reset_n),
	.load_strobe_n (load_strobe_n),
	.frame_sel_n   (frame_sel_n),
	.inputWord     (inputWord),
	.dacWord       (dacWord),
	.outGround     (outGround),
	.newData       (newData),
	.frameActive   (frameActive)
);

// >>> dac_host_model.sv
`timescale 1ns/100ps
module dac_host_model (
	output logic sclk,
	output logic frame_sel_n,
	output logic serial_in
);
	initial {sclk, frame_sel_n, serial_in} = 3'h6;
	// Sends the first n bits of w, most significant first; the clock idles high.
	task automatic send(input logic [23:0] w, input int n);
		#1 frame_sel_n = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			serial_in = w[23 - i];
			#80 sclk = 1'b0;
			#80 sclk = 1'b1;
		end
		#80 frame_sel_n = 1'b1;
		serial_in = ~serial_in;
	endtask
endmodule

// >>> dac_serial_load_control_test.sv
`timescale 1ns/100ps
module dac_serial_load_control_test;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        load_strobe_n = 1'b1;
	logic        reset_n = 1'b1;
	logic        sclk, frame_sel_n, serial_in, outGround, newData, frameActive;
	logic [23:0] inputWord, dacWord;
	logic [7:0]  ctrlWord;
	int          mismatches = 0;
	int          checks_done = 0;
	dac_host_model dac_host_model_inst (
		.sclk        (sclk),
		.frame_sel_n (frame_sel_n),
		.serial_in   (serial_in)
	);
	dac_serial_load_control dac_serial_load_control_inst (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.sclk          (sclk),
		.frame_sel_n   (frame_sel_n),
		.serial_in     (serial_in),
		.load_strobe_n (load_strobe_n),
		.reset_n       (reset_n),
		.inputWord     (inputWord),
		.dacWord       (dacWord),
		.ctrlWord      (ctrlWord),
		.outGround     (outGround),
		.newData       (newData),
		.frameActive   (frameActive)
	);
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	task chk(input logic [24:0] g, input logic [24:0] e);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected at %0t: %h %h", $time, g, e);
		end
	endtask
	// Sends one frame and looks at the shift flag while its bits still arrive.
	task frame(input logic [23:0] w, input int n, input logic act);
		fork
			dac_host_model_inst.send(w, n);
			begin
				repeat (40) @(negedge clk);
				chk({24'h0, frameActive}, {24'h0, act});
			end
		join
		repeat (9) @(negedge clk);
		chk({24'h0, frameActive}, 25'h0);
	endtask
	task reset_defaults;
		repeat (9) @(negedge clk);
		chk({outGround, inputWord | dacWord | {16'h0, ctrlWord}}, 25'h0);
	endtask
	task pulse_load;
		frame(24'ha5c3e1, 24, 1'b1);
		chk({newData, inputWord}, 25'h1a5c3e1);
		chk({1'b0, dacWord}, 25'h0);
		strobe(1'b0);
		strobe(1'b1);
		chk({newData, dacWord}, 25'h0a5c3e1);
	endtask
	task short_frame;
		frame(24'h123456, 23, 1'b1);
		chk({newData, inputWord}, 25'h0a5c3e1);
	endtask
	task held_load;
		strobe(1'b0);
		frame(24'h5a0f96, 24, 1'b1);
		chk({newData, dacWord}, 25'h05a0f96);
	endtask
	task pin_reset;
		reset_n = 1'b0;
		frame(24'hffffff, 24, 1'b0);
		strobe(1'b1);
		strobe(1'b0);
		chk({outGround, inputWord | dacWord}, 25'h1000000);
		@(negedge clk) reset_n = 1'b1;
		repeat (9) @(negedge clk);
		chk({outGround, dacWord}, 25'h0);
		frame(24'h3c96a5, 24, 1'b1);
		chk({newData, dacWord}, 25'h03c96a5);
	endtask
	task strobe(input logic v);
		@(negedge clk) load_strobe_n = v;
		repeat (6) @(negedge clk);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		reset_defaults;
		pulse_load;
		short_frame;
		held_load;
		pin_reset;
		end_sim;
	end
	initial
	begin
		#100000;
		mismatches++;
		end_sim;
	end
endmodule
